// ---- inc/cdrcs_consts.svh ----
// Offsets, field positions, reset values and timing counts of the CDR register bank.
`ifndef CDRCS_CONSTS_SVH
`define CDRCS_CONSTS_SVH

// Register offsets on the two-wire register port.
`define CDRCS_OFS_FREQ_LOW 8'h00
`define CDRCS_OFS_FREQ_MID 8'h01
`define CDRCS_OFS_FREQ_HIGH 8'h02
`define CDRCS_OFS_COARSE_RATE 8'h03
`define CDRCS_OFS_LINK_STATUS 8'h04
`define CDRCS_OFS_RATE_REF_CTRL 8'h08
`define CDRCS_OFS_LOCK_RST_CTRL 8'h09
`define CDRCS_OFS_OUTPUT_CTRL 8'h11

// Reset value of every writable control register.
`define CDRCS_CTRL_RESET 8'h00

// Field positions in link_status.
`define CDRCS_ST_ABSENT 5
`define CDRCS_ST_STICKY_LOST 4
`define CDRCS_ST_LOCK_LOST 3
`define CDRCS_ST_MEAS_DONE 2
`define CDRCS_ST_COARSE_LSB 0

// Field positions in rate_reference_control.
`define CDRCS_RR_RANGE_HI 7
`define CDRCS_RR_RANGE_LO 6
`define CDRCS_RR_EXP_HI 5
`define CDRCS_RR_EXP_LO 2
`define CDRCS_RR_MEASURE 1
`define CDRCS_RR_LOCK_REF 0
`define CDRCS_EXP_MAX 4'h8

// Field positions in lock_reset_control.
`define CDRCS_LR_CFG_PIN 7
`define CDRCS_LR_CLR_STATIC 6
`define CDRCS_LR_SYS_RESET 5
`define CDRCS_LR_CLR_DONE 3

// Field positions in output_control.
`define CDRCS_OC_ABSENT_LOW 2
`define CDRCS_OC_MUTE_MODE 1
`define CDRCS_OC_BOOST 0

// Lock detector thresholds in ppm.
`define CDRCS_LOST_SET_PPM 11'h3e8
`define CDRCS_LOST_CLR_PPM 11'h0fa

// Rate measurement window in clock cycles and counter widths.
`define CDRCS_MEAS_CYCLES 13'h1000
`define CDRCS_COUNT_MAX 23'h7fffff

`endif

// ---- inc/cdrcs_pkg.sv ----
// Types shared by the CDR register bank modules.
package cdrcs_pkg;

  // States of the data-rate measurement sequencer, one-hot.
  typedef enum logic [2:0] {
    CDRCS_MEAS_IDLE = 3'b001,
    CDRCS_MEAS_RUN = 3'b010,
    CDRCS_MEAS_DONE = 3'b100
  } cdrcs_meas_t;

endpackage

// ---- src/cdrcs_lock_detect.sv ----
// Lock detector with hysteresis and a sticky loss-of-lock flag.
`timescale 1ns/100ps
`include "cdrcs_consts.svh"
module cdrcs_lock_detect (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic soft_rst,
  // Frequency deviation and sticky clear.
  input wire logic [10:0] freq_err_ppm,
  input wire logic clr_static,
  // Live and sticky flags.
  output logic lost_live,
  output logic lost_sticky
);

  // Live flag and sticky flag state.
  logic live_reg;
  logic live_next;
  logic stat_reg;
  logic stat_next;
  logic rise;

  // Next-state logic for both flags.
  always_comb begin
    live_next = live_reg;
    if (freq_err_ppm > `CDRCS_LOST_SET_PPM) begin
      live_next = 1'b1;
    end else if (freq_err_ppm <= `CDRCS_LOST_CLR_PPM) begin
      live_next = 1'b0;
    end
    rise = live_next & ~live_reg;
    stat_next = stat_reg;
    if (rise) begin
      stat_next = 1'b1;
    end else if (clr_static) begin
      stat_next = 1'b0;
    end
    if (soft_rst) begin
      live_next = 1'b1;
      stat_next = 1'b0;
    end
  end

  // Register the flags; the loop starts out acquiring.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      live_reg <= 1'b1;
      stat_reg <= 1'b0;
    end else begin
      live_reg <= live_next;
      stat_reg <= stat_next;
    end
  end

  assign lost_live = live_reg;
  assign lost_sticky = stat_reg;

endmodule

// ---- src/cdrcs_rate_meas.sv ----
// Data-rate measurement: counts data edges over a fixed window.
`timescale 1ns/100ps
`include "cdrcs_consts.svh"
module cdrcs_rate_meas
  import cdrcs_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  input wire logic soft_rst,
  // Control.
  input wire logic start,
  input wire logic data_edge,
  // Result.
  output logic done_pulse,
  output logic busy,
  output logic [22:0] count
);

  // Sequencer, window timer and edge counter.
  cdrcs_meas_t st_reg;
  cdrcs_meas_t st_next;
  logic [12:0] win_reg;
  logic [12:0] win_next;
  logic [22:0] cnt_reg;
  logic [22:0] cnt_next;

  // Next-state logic; a new start restarts a running window.
  always_comb begin
    st_next = st_reg;
    win_next = win_reg;
    cnt_next = cnt_reg;
    done_pulse = 1'b0;
    case (st_reg)
      CDRCS_MEAS_RUN: begin
        win_next = win_reg - 13'h0001;
        // Saturate rather than wrap on very fast data.
        if (data_edge && cnt_reg != `CDRCS_COUNT_MAX) begin
          cnt_next = cnt_reg + 23'h000001;
        end
        if (win_reg == 13'h0001) begin
          st_next = CDRCS_MEAS_DONE;
          done_pulse = 1'b1;
        end
      end
      CDRCS_MEAS_IDLE, CDRCS_MEAS_DONE: begin
      end
      default: begin
        st_next = CDRCS_MEAS_IDLE;
      end
    endcase
    if (start) begin
      st_next = CDRCS_MEAS_RUN;
      win_next = `CDRCS_MEAS_CYCLES;
      cnt_next = 23'h000000;
      done_pulse = 1'b0;
    end
    if (soft_rst) begin
      st_next = CDRCS_MEAS_IDLE;
      cnt_next = 23'h000000;
      done_pulse = 1'b0;
    end
  end

  // Register the sequencer.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= CDRCS_MEAS_IDLE;
      win_reg <= 13'h0000;
      cnt_reg <= 23'h000000;
    end else begin
      st_reg <= st_next;
      win_reg <= win_next;
      cnt_reg <= cnt_next;
    end
  end

  assign busy = (st_reg == CDRCS_MEAS_RUN);
  assign count = cnt_reg;

endmodule

// ---- src/cdrcs_regs.sv ----
// Control and status register bank of the clock and data recovery receiver.
//
// Functional notes
// - Nine-bit coarse rate split across two registers.
// - Status shows signal loss and acquisition.
// - Sticky loss-of-lock flag held until cleared.
// - Measure-done bit low while measuring.
// - Writing measure bit starts rate measurement.
// - Lock source: data or reference clock.
// - Four-bit exponent sets rate ratio, max 256.
// - Lock pin shows live or sticky flag.
// - One-then-zero writes clear flags or reset.
// - Mute mode: both outputs or one.
// - Output swing default or boosted.
// - Control registers reset to zero.
// - Lock lost above deviation threshold.
// - Lock regained inside lock window.
// - Mute input disables outputs per mode.
`timescale 1ns/100ps
`include "cdrcs_consts.svh"
module cdrcs_regs
  import cdrcs_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Decoded register port from the two-wire framer.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Analog front-end status.
  input wire logic signal_absent_in,
  input wire logic [10:0] freq_err_ppm,
  input wire logic data_edge,
  // Mute pin.
  input wire logic output_mute,
  // Status pins.
  output logic lock_lost,
  output logic signal_absent,
  // Controls to the recovery loops and output stage.
  output logic lock_to_reference,
  output logic [1:0] ref_range,
  output logic [3:0] rate_exponent,
  output logic output_boost,
  output logic clk_out_en,
  output logic data_out_en
);

  // Stored control fields; reserved bits are not kept.
  logic [1:0] range_reg;
  logic [1:0] range_next;
  logic [3:0] exp_reg;
  logic [3:0] exp_next;
  logic lock_ref_reg;
  logic lock_ref_next;
  logic cfg_pin_reg;
  logic cfg_pin_next;
  logic clr_st_reg;
  logic clr_st_next;
  logic sys_rst_reg;
  logic sys_rst_next;
  logic clr_done_reg;
  logic clr_done_next;
  logic absent_low_reg;
  logic absent_low_next;
  logic mute_mode_reg;
  logic mute_mode_next;
  logic boost_reg;
  logic boost_next;
  // Soft reset pulse, one cycle after the one-then-zero write.
  logic soft_rst_reg;
  logic soft_rst_next;

  // Measurement results and status.
  logic [22:0] freq_reg;
  logic [22:0] freq_next;
  logic done_reg;
  logic done_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;

  // Decoded strobes and submodule outputs.
  logic wr_rr;
  logic wr_lr;
  logic wr_oc;
  logic meas_start;
  logic clr_static;
  logic clr_done;
  logic meas_done;
  logic meas_busy;
  logic [22:0] meas_count;
  logic lost_live;
  logic lost_sticky;
  logic [8:0] coarse;
  logic [7:0] status;

  // Address decode of the three writable registers.
  assign wr_rr = reg_wr && (reg_addr == `CDRCS_OFS_RATE_REF_CTRL);
  assign wr_lr = reg_wr && (reg_addr == `CDRCS_OFS_LOCK_RST_CTRL);
  assign wr_oc = reg_wr && (reg_addr == `CDRCS_OFS_OUTPUT_CTRL);

  assign meas_start = wr_rr && reg_wdata[`CDRCS_RR_MEASURE];

  assign clr_static = wr_lr && clr_st_reg && !reg_wdata[`CDRCS_LR_CLR_STATIC];
  assign clr_done = wr_lr && clr_done_reg && !reg_wdata[`CDRCS_LR_CLR_DONE];

  // Lock detector with sticky flag.
  cdrcs_lock_detect u_lock (
    .clock(clock),
    .rst_b(rst_b),
    .soft_rst(soft_rst_reg),
    .freq_err_ppm(freq_err_ppm),
    .clr_static(clr_static),
    .lost_live(lost_live),
    .lost_sticky(lost_sticky)
  );

  // Data-rate measurement sequencer.
  cdrcs_rate_meas u_meas (
    .clock(clock),
    .rst_b(rst_b),
    .soft_rst(soft_rst_reg),
    .start(meas_start),
    .data_edge(data_edge),
    .done_pulse(meas_done),
    .busy(meas_busy),
    .count(meas_count)
  );

  // Control register next values. Writes only ever change the fields
  // of the addressed register; the soft reset returns all of them to
  // zero, which also stops a half-written reset sequence repeating.
  always_comb begin
    range_next = range_reg;
    exp_next = exp_reg;
    lock_ref_next = lock_ref_reg;
    cfg_pin_next = cfg_pin_reg;
    clr_st_next = clr_st_reg;
    sys_rst_next = sys_rst_reg;
    clr_done_next = clr_done_reg;
    absent_low_next = absent_low_reg;
    mute_mode_next = mute_mode_reg;
    boost_next = boost_reg;
    soft_rst_next = 1'b0;
    if (wr_rr) begin
      range_next = reg_wdata[`CDRCS_RR_RANGE_HI:`CDRCS_RR_RANGE_LO];
      exp_next = reg_wdata[`CDRCS_RR_EXP_HI:`CDRCS_RR_EXP_LO];
      lock_ref_next = reg_wdata[`CDRCS_RR_LOCK_REF];
    end
    if (wr_lr) begin
      cfg_pin_next = reg_wdata[`CDRCS_LR_CFG_PIN];
      clr_st_next = reg_wdata[`CDRCS_LR_CLR_STATIC];
      clr_done_next = reg_wdata[`CDRCS_LR_CLR_DONE];
      sys_rst_next = reg_wdata[`CDRCS_LR_SYS_RESET];
      soft_rst_next = sys_rst_reg && !reg_wdata[`CDRCS_LR_SYS_RESET];
    end
    if (wr_oc) begin
      absent_low_next = reg_wdata[`CDRCS_OC_ABSENT_LOW];
      mute_mode_next = reg_wdata[`CDRCS_OC_MUTE_MODE];
      boost_next = reg_wdata[`CDRCS_OC_BOOST];
    end
    if (soft_rst_reg) begin
      range_next = 2'h0;
      exp_next = 4'h0;
      lock_ref_next = 1'b0;
      cfg_pin_next = 1'b0;
      clr_st_next = 1'b0;
      sys_rst_next = 1'b0;
      clr_done_next = 1'b0;
      absent_low_next = 1'b0;
      mute_mode_next = 1'b0;
      boost_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      range_reg <= 2'h0;
      exp_reg <= 4'h0;
      lock_ref_reg <= 1'b0;
      cfg_pin_reg <= 1'b0;
      clr_st_reg <= 1'b0;
      sys_rst_reg <= 1'b0;
      clr_done_reg <= 1'b0;
      absent_low_reg <= 1'b0;
      mute_mode_reg <= 1'b0;
      boost_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else begin
      range_reg <= range_next;
      exp_reg <= exp_next;
      lock_ref_reg <= lock_ref_next;
      cfg_pin_reg <= cfg_pin_next;
      clr_st_reg <= clr_st_next;
      sys_rst_reg <= sys_rst_next;
      clr_done_reg <= clr_done_next;
      absent_low_reg <= absent_low_next;
      mute_mode_reg <= mute_mode_next;
      boost_reg <= boost_next;
      soft_rst_reg <= soft_rst_next;
    end
  end

  // Measurement result and completion flag. The readback keeps the
  // previous result while a new window runs, so software never sees a
  // partial count.
  always_comb begin
    freq_next = freq_reg;
    done_next = done_reg;
    if (meas_done) begin
      freq_next = meas_count;
    end
    if (meas_busy || meas_start) begin
      done_next = 1'b0;
    end
    if (meas_done) begin
      done_next = 1'b1;
    end else if (clr_done) begin
      done_next = 1'b0;
    end
    if (soft_rst_reg) begin
      freq_next = 23'h000000;
      done_next = 1'b0;
    end
  end

  // Register the result.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      freq_reg <= 23'h000000;
      done_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      done_reg <= done_next;
    end
  end

  assign coarse = freq_reg[22:14];

  // Status byte; unused bits read as zero.
  always_comb begin
    status = 8'h00;
    status[`CDRCS_ST_ABSENT] = signal_absent_in;
    status[`CDRCS_ST_LOCK_LOST] = lost_live;
    status[`CDRCS_ST_STICKY_LOST] = lost_sticky;
    status[`CDRCS_ST_MEAS_DONE] = done_reg;
    status[`CDRCS_ST_COARSE_LSB] = coarse[0];
  end

  // Read mux. only the status side answers; control offsets and
  // unmapped offsets read zero because controls cannot be read back.
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      case (reg_addr)
        `CDRCS_OFS_FREQ_LOW: begin
          rdata_next = freq_reg[7:0];
        end
        `CDRCS_OFS_FREQ_MID: begin
          rdata_next = freq_reg[15:8];
        end
        `CDRCS_OFS_FREQ_HIGH: begin
          rdata_next = {1'b0, freq_reg[22:16]};
        end
        `CDRCS_OFS_COARSE_RATE: begin
          rdata_next = coarse[8:1];
        end
        `CDRCS_OFS_LINK_STATUS: begin
          rdata_next = status;
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // Register the read answer.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  assign lock_lost = cfg_pin_reg ? lost_sticky : lost_live;
  // Signal-absent pin polarity is selectable.
  assign signal_absent = signal_absent_in ^ absent_low_reg;

  assign lock_to_reference = lock_ref_reg;
  assign ref_range = range_reg;
  assign rate_exponent = (exp_reg > `CDRCS_EXP_MAX) ? `CDRCS_EXP_MAX : exp_reg;
  assign output_boost = boost_reg;

  assign clk_out_en = !(output_mute && !mute_mode_reg);
  assign data_out_en = !output_mute;

endmodule

// ---- testbench/cdrcs_regs_monitor.sv ----
// Port-level assertions for the CDR register bank.
`timescale 1ns/100ps
module cdrcs_regs_monitor (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Pins and controls.
  input wire logic output_mute,
  input wire logic lock_to_reference,
  input wire logic [1:0] ref_range,
  input wire logic [3:0] rate_exponent,
  input wire logic output_boost,
  input wire logic clk_out_en,
  input wire logic data_out_en
);
  // All checks share one clock, and reset silences them.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_stray;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray read valid");
  property p_wo_zero;
    reg_rd && (reg_addr inside {8'h08, 8'h09, 8'h11}) |=> reg_rdata == 8'h00;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("control read not zero");
  property p_lock_src;
    reg_wr && reg_addr == 8'h08 |=> lock_to_reference == $past(reg_wdata[0]);
  endproperty
  a_lock_src: assert property (p_lock_src) else $error("lock source wrong");
  property p_range;
    reg_wr && reg_addr == 8'h08 |=> ref_range == $past(reg_wdata[7:6]);
  endproperty
  a_range: assert property (p_range) else $error("reference band wrong");
  property p_exp;
    reg_wr && reg_addr == 8'h08 |=> rate_exponent ==
      (($past(reg_wdata[5:2]) > 4'h8) ? 4'h8 : $past(reg_wdata[5:2]));
  endproperty
  a_exp: assert property (p_exp) else $error("rate exponent wrong");
  property p_boost;
    reg_wr && reg_addr == 8'h11 |=> output_boost == $past(reg_wdata[0]);
  endproperty
  a_boost: assert property (p_boost) else $error("swing control wrong");
  property p_ctrl_reset;
    $rose(rst_b) |-> !lock_to_reference && ref_range == 2'h0 && !output_boost;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero");
  property p_mute_data;
    output_mute |-> !data_out_en;
  endproperty
  a_mute_data: assert property (p_mute_data) else $error("data not muted");
  property p_unmuted;
    !output_mute |-> clk_out_en && data_out_en;
  endproperty
  a_unmuted: assert property (p_unmuted) else $error("output muted idle");
  // Main scenarios: measurement start, clock kept in one-output mute, done seen.
  c_start: cover property (reg_wr && reg_addr == 8'h08 && reg_wdata[1]);
  c_mute_one: cover property (output_mute && clk_out_en);
  c_done: cover property (reg_rvalid && reg_rdata[2]);
endmodule
bind cdrcs_regs cdrcs_regs_monitor u_monitor (
  .clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .output_mute(output_mute),
  .lock_to_reference(lock_to_reference), .ref_range(ref_range),
  .rate_exponent(rate_exponent), .output_boost(output_boost),
  .clk_out_en(clk_out_en), .data_out_en(data_out_en)
);

// ---- testbench/cdrcs_host_model.sv ----
// Bus controller model driving the decoded register port.
`timescale 1ns/100ps
module cdrcs_host_model (
  // Clock.
  input wire logic clock,
  // Requests.
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  // Answers.
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Copy of lock_reset_control, since the device cannot read it back.
  logic [7:0] shadow_b;
  // Idle bus at time zero.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    shadow_b = 8'h00;
  end
  // One write; address and data are scrambled once taken, so stale values never help.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // One read; to stays high if no answer comes within four edges.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic to);
    to = 1'b1;
    d = 8'h00;
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (int i = 0; i < 4 && to; i++) begin
      @(posedge clock);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        to = 1'b0;
      end
    end
  endtask
  task automatic set_b(input logic [7:0] d);
    shadow_b = d & 8'he8;
    wr(8'h09, shadow_b);
  endtask
  task automatic pulse_b(input logic [7:0] m);
    wr(8'h09, shadow_b | m);
    wr(8'h09, shadow_b & ~m);
  endtask
endmodule

// ---- testbench/cdrcs_regs_tb.sv ----
// Self-checking testbench of the CDR register bank.
`timescale 1ns/100ps
module cdrcs_regs_tb;
  // Design inputs and outputs.
  logic clock, rst_b, reg_wr, reg_rd, reg_rvalid, signal_absent_in, output_mute;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [10:0] freq_err_ppm;
  logic data_edge = 1'b0;
  logic lock_lost, signal_absent, lock_to_reference, output_boost, clk_out_en, data_out_en;
  logic [1:0] ref_range;
  logic [3:0] rate_exponent;
  logic to;
  int n_errors = 0;
  int num_checks = 0;
  cdrcs_regs dut (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .signal_absent_in(signal_absent_in),
    .freq_err_ppm(freq_err_ppm), .data_edge(data_edge), .output_mute(output_mute),
    .lock_lost(lock_lost), .signal_absent(signal_absent),
    .lock_to_reference(lock_to_reference), .ref_range(ref_range),
    .rate_exponent(rate_exponent), .output_boost(output_boost),
    .clk_out_en(clk_out_en), .data_out_en(data_out_en));
  cdrcs_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  // Clock of 8 ns.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // A data edge every other cycle, so any 4096-cycle window holds 2048.
  always @(posedge clock) data_edge <= #1 ~data_edge;
  // Verdict and end of run.
  task automatic final_report();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Compare one value.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read a register and compare the masked bits; a lost answer ends the run.
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    host.rd(a, d, to);
    if (to) begin
      n_errors++;
      $display("[FAIL] %0t read not answered", $time);
      final_report();
    end else begin
      chk(d & m, exp);
    end
  endtask
  // Let n edges pass, then settle off the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    signal_absent_in = 1'b0;
    output_mute = 1'b0;
    freq_err_ppm = 11'h7ff;
    repeat (2) @(posedge clock);
    #1;
    rst_b = 1'b1;
    rdc(8'h04, 8'hff, 8'h08);
    rdc(8'h08, 8'hff, 8'h00);
    rdc(8'h09, 8'hff, 8'h00);
    rdc(8'h11, 8'hff, 8'h00);
    rdc(8'h05, 8'hff, 8'h00);
    freq_err_ppm = 11'h064;
    cyc(2);
    chk({7'h00, lock_lost}, 8'h00);
    rdc(8'h04, 8'hff, 8'h00);
    freq_err_ppm = 11'h3e8;
    cyc(2);
    chk({7'h00, lock_lost}, 8'h00);
    freq_err_ppm = 11'h3e9;
    cyc(2);
    chk({7'h00, lock_lost}, 8'h01);
    freq_err_ppm = 11'h0fb;
    cyc(2);
    chk({7'h00, lock_lost}, 8'h01);
    freq_err_ppm = 11'h0fa;
    cyc(2);
    chk({7'h00, lock_lost}, 8'h00);
    rdc(8'h04, 8'hff, 8'h10);
    host.set_b(8'h80);
    chk({7'h00, lock_lost}, 8'h01);
    host.pulse_b(8'h40);
    chk({7'h00, lock_lost}, 8'h00);
    rdc(8'h04, 8'hff, 8'h00);
    host.set_b(8'h00);
    signal_absent_in = 1'b1;
    cyc(1);
    chk({7'h00, signal_absent}, 8'h01);
    rdc(8'h04, 8'h20, 8'h20);
    host.wr(8'h11, 8'h04);
    chk({7'h00, signal_absent}, 8'h00);
    signal_absent_in = 1'b0;
    host.wr(8'h11, 8'h00);
    for (int i = 0; i < 10; i++) begin
      host.wr(8'h08, {i[1:0], i[3:0], 1'b0, i[0]});
      chk({6'h00, ref_range}, {6'h00, i[1:0]});
      chk({4'h0, rate_exponent}, (i > 8) ? 8'h08 : i[7:0]);
      chk({7'h00, lock_to_reference}, {7'h00, i[0]});
    end
    output_mute = 1'b1;
    cyc(1);
    chk({6'h00, clk_out_en, data_out_en}, 8'h00);
    host.wr(8'h11, 8'h03);
    chk({6'h00, clk_out_en, data_out_en}, 8'h02);
    chk({7'h00, output_boost}, 8'h01);
    output_mute = 1'b0;
    cyc(1);
    chk({6'h00, clk_out_en, data_out_en}, 8'h03);
    host.pulse_b(8'h20);
    cyc(1);
    chk({6'h00, lock_to_reference, output_boost}, 8'h00);
    host.wr(8'h08, 8'h02);
    rdc(8'h04, 8'h04, 8'h00);
    d = 8'h00;
    for (int i = 0; i < 3000 && d[2] !== 1'b1; i++) begin
      host.rd(8'h04, d, to);
    end
    if (d[2] !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t measurement never completed", $time);
      final_report();
    end
    chk(d & 8'h05, 8'h04);
    rdc(8'h00, 8'hff, 8'h00);
    rdc(8'h01, 8'hff, 8'h08);
    rdc(8'h02, 8'hff, 8'h00);
    rdc(8'h03, 8'hff, 8'h00);
    host.pulse_b(8'h08);
    rdc(8'h04, 8'h04, 8'h00);
    final_report();
  end
endmodule
